// File: pcsi_map.svh
// Purpose: offsets, fields, reset values and counts of the program counter core
// Assumes: byte addresses on a 32-bit classic Wishbone bus, one register per word
// Notes: definitions only
`ifndef PCSI_MAP_SVH
`define PCSI_MAP_SVH

// register byte addresses
`define PCSI_ADR_INDIRECT_DATA_PORT 8'h00
`define PCSI_ADR_PC_LOW_BYTE 8'h04
`define PCSI_ADR_STATUS 8'h08
`define PCSI_ADR_POINTER_REGISTER 8'h0C
`define PCSI_ADR_PC_HIGH_LATCH 8'h10

// widths and fields
`define PCSI_PC_W 13
`define PCSI_OPERAND_W 11
`define PCSI_LATCH_W 5
`define PCSI_LATCH_JUMP_HI 4
`define PCSI_LATCH_JUMP_LO 3
`define PCSI_STATUS_BANK_BIT 7
`define PCSI_EFF_ADDR_W 9
`define PCSI_STACK_DEPTH 8
`define PCSI_STACK_PTR_W 3

// reset values
`define PCSI_PC_RESET 13'h0000
`define PCSI_BYTE_RESET 8'h00
`define PCSI_LATCH_RESET 5'h00
`define PCSI_PTR_RESET 3'h0

// fixed addresses
`define PCSI_INT_VECTOR 13'h0004
`define PCSI_PORT_SELF_MASK 8'h7F
`define PCSI_PORT_SELF 8'h00

`endif

// File: pcsi_pkg.sv
// Purpose: types shared by the program counter core
// Assumes: constants live in pcsi_map.svh
// Notes: none
package pcsi_pkg;

  // control-flow request from the instruction decoder
  typedef enum logic [2:0] {
    PCSI_OP_INCREMENT = 3'h0,
    PCSI_OP_CALL = 3'h1,
    PCSI_OP_DIRECT_JUMP = 3'h2,
    PCSI_OP_RETURN = 3'h3,
    PCSI_OP_EXIT_WITH_LITERAL = 3'h4,
    PCSI_OP_EXIT_FROM_INTERRUPT = 3'h5,
    PCSI_OP_INT_VECTOR = 3'h6,
    PCSI_OP_NONE = 3'h7
  } pcsi_op_type;

  // bus slave sequencing
  typedef enum logic [1:0] {
    PCSI_ST_IDLE = 2'b01,
    PCSI_ST_FILE = 2'b10
  } pcsi_state_type;

endpackage

// File: pcsi_stack_if.sv
// Purpose: carries push and pop between the core and its return stack
// Assumes: one request per cycle, never push and pop together
// Notes: top_data is registered inside the stack
`timescale 1ns/100ps
`default_nettype none
`include "pcsi_map.svh"

interface pcsi_stack_if;
  logic push;
  logic pop;
  logic [`PCSI_PC_W-1:0] push_data;
  logic [`PCSI_PC_W-1:0] top_data;

  modport core (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

`default_nettype wire

// File: pcsi_stack.sv
// Purpose: eight-entry circular return stack
// Assumes: caller never pushes and pops in one cycle
// Notes: no overflow or underflow indication; pointer is internal only
`timescale 1ns/100ps
`default_nettype none
`include "pcsi_map.svh"

module pcsi_stack (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // core side
  pcsi_stack_if.stack stk
);

  logic [`PCSI_PC_W-1:0] mem_reg [`PCSI_STACK_DEPTH];
  // no over/underflow flag: wrap is silent by design
  logic [`PCSI_STACK_PTR_W-1:0] ptr_reg;
  logic [`PCSI_STACK_PTR_W-1:0] ptr_next;
  logic [`PCSI_PC_W-1:0] top_reg;
  logic [`PCSI_PC_W-1:0] top_next;
  logic [`PCSI_STACK_PTR_W-1:0] below_idx;

  // 3-bit pointer wraps by itself: ninth push lands on the first slot
  assign ptr_next = stk.push ? ptr_reg + 3'h1 : (stk.pop ? ptr_reg - 3'h1 : ptr_reg);
  assign below_idx = ptr_reg - 3'h2;
  assign top_next = stk.push ? stk.push_data : (stk.pop ? mem_reg[below_idx] : top_reg);
  assign stk.top_data = top_reg;

  // storage itself is not reset; only the pointer and the top register get a defined value
  always_ff @(posedge clk) begin
    if (stk.push) begin
      mem_reg[ptr_reg] <= stk.push_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= `PCSI_PTR_RESET;
      top_reg <= `PCSI_PC_RESET;
    end else begin
      ptr_reg <= ptr_next;
      top_reg <= top_next;
    end
  end

  AST_STACK_PUSH_TOP: assert property (@(posedge clk) disable iff (reset)
    stk.push |=> top_reg == $past(stk.push_data))
    else $error("stack top does not hold pushed value");

  AST_STACK_WRAP: assert property (@(posedge clk) disable iff (reset)
    stk.push |=> ptr_reg == $past(ptr_reg) + 3'h1)
    else $error("stack pointer did not advance modulo eight");

endmodule

`default_nettype wire

// File: pcsi_core.sv
// Purpose: program counter, return stack control and indirect data addressing
// Assumes: decoder issues one op per cycle; register file answers rf_ack
// Notes: registers reached over classic Wishbone, 32-bit data, byte lane 0
`timescale 1ns/100ps
`default_nettype none
`include "pcsi_map.svh"

// Functional notes
// - program counter is thirteen bits wide and addresses program memory
// - low counter byte is a software readable and writable register
// - upper counter bits cannot be read; software loads them only via the high latch
// - writing the low byte loads upper bits from latch bits 4 to 0
// - call and direct jump take top two bits from latch bits 4 and 3
// - any reset clears the upper counter bits
// - eight-entry, thirteen-bit return stack outside program and data space
// - software can neither read nor write the stack pointer
// - call or interrupt vectoring pushes the incremented counter onto the stack
// - return, exit with literal and exit from interrupt pop the stack
// - pushes and pops leave the high latch untouched
// - stack is circular; ninth push overwrites the first entry
// - no overflow or underflow status is provided
// - indirect port accesses the register addressed by the pointer
// - indirect read with the port selecting itself returns zero
// - indirect write with the port selecting itself stores nothing
// - effective address is bank bit above the eight pointer bits
module pcsi_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // instruction decoder
  input wire logic op_valid,
  input wire pcsi_pkg::pcsi_op_type op_kind,
  input wire logic [`PCSI_OPERAND_W-1:0] op_operand,
  output logic op_ready,
  output logic [`PCSI_PC_W-1:0] pc_out,
  // register file
  output logic rf_rd,
  output logic rf_wr,
  output logic [`PCSI_EFF_ADDR_W-1:0] rf_addr,
  output logic [7:0] rf_wdata,
  input wire logic [7:0] rf_rdata,
  input wire logic rf_ack
);

  pcsi_stack_if stk ();

  pcsi_stack u_stack (
    .clk(clk),
    .reset(reset),
    .stk(stk)
  );

  // state
  logic [`PCSI_PC_W-1:0] pc_reg;
  logic [`PCSI_PC_W-1:0] pc_next;
  logic [`PCSI_LATCH_W-1:0] latch_reg;
  logic [`PCSI_LATCH_W-1:0] latch_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic bank_reg;
  logic bank_next;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [`PCSI_EFF_ADDR_W-1:0] rf_addr_reg;
  logic [7:0] rf_wdata_reg;
  pcsi_pkg::pcsi_state_type state_reg;
  pcsi_pkg::pcsi_state_type state_next;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire lane0 = wb_sel_i[0];
  wire in_idle = state_reg == pcsi_pkg::PCSI_ST_IDLE;
  wire in_file = state_reg == pcsi_pkg::PCSI_ST_FILE;
  wire hit_ind = wb_adr_i == `PCSI_ADR_INDIRECT_DATA_PORT;
  wire hit_pcl = wb_adr_i == `PCSI_ADR_PC_LOW_BYTE;
  wire hit_stat = wb_adr_i == `PCSI_ADR_STATUS;
  wire hit_ptr = wb_adr_i == `PCSI_ADR_POINTER_REGISTER;
  wire hit_latch = wb_adr_i == `PCSI_ADR_PC_HIGH_LATCH;
  wire local_req = req & in_idle;
  wire wr_local = local_req & wb_we_i & lane0;
  wire wr_pcl = wr_local & hit_pcl;
  wire wr_latch = wr_local & hit_latch;
  wire wr_ptr = wr_local & hit_ptr;
  wire wr_stat = wr_local & hit_stat;

  // port selects itself when the pointer names the port in any bank
  wire ind_self = (ptr_reg & `PCSI_PORT_SELF_MASK) == `PCSI_PORT_SELF;
  wire ind_go = local_req & hit_ind & ~ind_self & (lane0 | ~wb_we_i);
  wire [`PCSI_EFF_ADDR_W-1:0] eff_addr = {bank_reg, ptr_reg};

  // counter sources
  wire [`PCSI_PC_W-1:0] pc_inc = pc_reg + 13'h0001;
  wire [`PCSI_PC_W-1:0] pc_from_low = {latch_reg, wb_dat_i[7:0]};
  wire [`PCSI_PC_W-1:0] pc_from_operand = {latch_reg[`PCSI_LATCH_JUMP_HI:`PCSI_LATCH_JUMP_LO], op_operand};
  wire op_take = op_valid & ~wr_pcl;
  wire is_call = op_kind == pcsi_pkg::PCSI_OP_CALL;
  wire is_vec = op_kind == pcsi_pkg::PCSI_OP_INT_VECTOR;
  wire is_ret = (op_kind == pcsi_pkg::PCSI_OP_RETURN) |
                (op_kind == pcsi_pkg::PCSI_OP_EXIT_WITH_LITERAL) |
                (op_kind == pcsi_pkg::PCSI_OP_EXIT_FROM_INTERRUPT);

  // a software write to the low byte wins; the decoder waits one cycle
  assign op_ready = ~wr_pcl;

  // return address is the counter after the current instruction
  assign stk.push = op_take & (is_call | is_vec);
  assign stk.pop = op_take & is_ret;
  assign stk.push_data = pc_inc;

  always_comb begin
    pc_next = pc_reg;
    if (wr_pcl) begin
      pc_next = pc_from_low;
    end else if (op_take) begin
      case (op_kind)
        pcsi_pkg::PCSI_OP_INCREMENT: pc_next = pc_inc;
        pcsi_pkg::PCSI_OP_CALL: pc_next = pc_from_operand;
        pcsi_pkg::PCSI_OP_DIRECT_JUMP: pc_next = pc_from_operand;
        pcsi_pkg::PCSI_OP_RETURN: pc_next = stk.top_data;
        pcsi_pkg::PCSI_OP_EXIT_WITH_LITERAL: pc_next = stk.top_data;
        pcsi_pkg::PCSI_OP_EXIT_FROM_INTERRUPT: pc_next = stk.top_data;
        pcsi_pkg::PCSI_OP_INT_VECTOR: pc_next = `PCSI_INT_VECTOR;
        default: pc_next = pc_reg;
      endcase
    end
  end

  // latch changes only by software; stack traffic never touches it
  assign latch_next = wr_latch ? wb_dat_i[`PCSI_LATCH_W-1:0] : latch_reg;
  assign ptr_next = wr_ptr ? wb_dat_i[7:0] : ptr_reg;
  assign bank_next = wr_stat ? wb_dat_i[`PCSI_STATUS_BANK_BIT] : bank_reg;

  // read data; upper counter bits and stack pointer have no read path
  wire [31:0] rd_pcl = {24'h000000, pc_reg[7:0]};
  wire [31:0] rd_stat = {24'h000000, bank_reg, 7'h00};
  wire [31:0] rd_ptr = {24'h000000, ptr_reg};
  wire [31:0] rd_latch = {27'h0000000, latch_reg};
  wire [31:0] rd_file = {24'h000000, rf_rdata};
  wire [31:0] rd_local;
  // unmapped addresses and a self-selecting port read as zero
  assign rd_local = hit_pcl ? rd_pcl :
                    hit_stat ? rd_stat :
                    hit_ptr ? rd_ptr :
                    hit_latch ? rd_latch : 32'h00000000;

  always_comb begin
    state_next = state_reg;
    dat_next = dat_reg;
    case (state_reg)
      pcsi_pkg::PCSI_ST_IDLE: begin
        if (ind_go) begin
          state_next = pcsi_pkg::PCSI_ST_FILE;
        end else if (local_req) begin
          dat_next = wb_we_i ? 32'h00000000 : rd_local;
        end
      end
      pcsi_pkg::PCSI_ST_FILE: begin
        if (rf_ack) begin
          state_next = pcsi_pkg::PCSI_ST_IDLE;
          dat_next = wb_we_i ? 32'h00000000 : rd_file;
        end
      end
      default: state_next = pcsi_pkg::PCSI_ST_IDLE;
    endcase
  end

  wire ack_next = (local_req & ~ind_go) | (in_file & rf_ack);

  // register file strobes held until the file answers
  assign rf_rd = in_file & ~wb_we_i;
  assign rf_wr = in_file & wb_we_i;
  assign rf_addr = rf_addr_reg;
  assign rf_wdata = rf_wdata_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign pc_out = pc_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_reg <= `PCSI_PC_RESET;
      latch_reg <= `PCSI_LATCH_RESET;
      ptr_reg <= `PCSI_BYTE_RESET;
      bank_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      latch_reg <= latch_next;
      ptr_reg <= ptr_next;
      bank_reg <= bank_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= pcsi_pkg::PCSI_ST_IDLE;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rf_addr_reg <= 9'h000;
      rf_wdata_reg <= `PCSI_BYTE_RESET;
    end else if (ind_go) begin
      rf_addr_reg <= eff_addr;
      rf_wdata_reg <= wb_dat_i[7:0];
    end
  end

  // checks
  AST_PCL_LOAD: assert property (@(posedge clk) disable iff (reset)
    wr_pcl |=> pc_reg == {$past(latch_reg), $past(wb_dat_i[7:0])})
    else $error("low byte write did not load counter from latch");

  AST_JUMP_LOAD: assert property (@(posedge clk) disable iff (reset)
    (op_take && op_kind == pcsi_pkg::PCSI_OP_DIRECT_JUMP) |=>
      pc_reg[12:11] == $past(latch_reg[4:3]) && pc_reg[10:0] == $past(op_operand))
    else $error("direct jump did not combine latch and operand");

  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (reset)
    (op_take && is_call) |=> stk.top_data == $past(pc_reg) + 13'h0001)
    else $error("call did not push return address");

  AST_RET_POP: assert property (@(posedge clk) disable iff (reset)
    (op_take && is_ret) |=> pc_reg == $past(stk.top_data))
    else $error("return did not load counter from stack top");

  AST_LATCH_KEPT: assert property (@(posedge clk) disable iff (reset)
    ((stk.push || stk.pop) && !wr_latch) |=> $stable(latch_reg))
    else $error("stack traffic disturbed the high latch");

  AST_SELF_READ_ZERO: assert property (@(posedge clk) disable iff (reset)
    (local_req && hit_ind && ind_self && !wb_we_i) |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("self-selected indirect read was not zero");

  AST_SELF_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
    (local_req && hit_ind && ind_self) |=> !rf_wr && !rf_rd)
    else $error("self-selected indirect access reached the file");

  AST_EFF_ADDR: assert property (@(posedge clk) disable iff (reset)
    ind_go |=> rf_addr == {$past(bank_reg), $past(ptr_reg)} && (rf_rd || rf_wr))
    else $error("effective address wrong");

  AST_INC_13BIT: assert property (@(posedge clk) disable iff (reset)
    (op_take && op_kind == pcsi_pkg::PCSI_OP_INCREMENT) |=> pc_reg == $past(pc_reg) + 13'h0001)
    else $error("counter did not increment");

  AST_ACK_DROP: assert property (@(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  COV_CALL: cover property (@(posedge clk) disable iff (reset) op_take && is_call);
  COV_RET: cover property (@(posedge clk) disable iff (reset) op_take && is_ret);
  COV_IND_READ: cover property (@(posedge clk) disable iff (reset) rf_rd && rf_ack);
  COV_PCL_WRITE: cover property (@(posedge clk) disable iff (reset) wr_pcl);

endmodule

`default_nettype wire

// File: tb_program_counter_stack_indirect.sv
// Purpose: self-checking bench for the program counter, return stack and indirect path
// Assumes: register file answered by the bench with random stalls
// Notes: the stack model mirrors pushes and pops so that wrapped pops are predicted
`timescale 1ns/100ps
`default_nettype none
`include "pcsi_map.svh"

module tb_program_counter_stack_indirect;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_valid, op_ready;
  logic rf_rd, rf_wr, rf_ack, seen_wr;
  logic [7:0] wb_adr_i, rf_wdata, rf_rdata, rf_sent, seen_wd, lat8, p;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat, r, seed, mismatches, compares, cycles, rf_count, n0;
  logic [31:0] rf_r, blocked, b0;
  pcsi_pkg::pcsi_op_type op_kind;
  logic [10:0] op_operand;
  logic [12:0] pc_out, exp_pc;
  logic [8:0] rf_addr, seen_addr;
  logic [12:0] stk [0:7];
  logic [2:0] sp;
  logic [1:0] stall;
  logic [4:0] lat;
  int i;

  pcsi_core dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .op_valid(op_valid), .op_kind(op_kind), .op_operand(op_operand), .op_ready(op_ready), .pc_out(pc_out),
    .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .rf_ack(rf_ack));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares != 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    compares = compares + 1;
    if (seen !== expected) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // hang guard: whole run is a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 32'h4E20) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end

  // register file: random stall, ack for one cycle with a random data byte, data line toggled otherwise except while stalled
  always @(posedge clk) begin
    if (rf_ack) begin
      rf_ack <= 1'b0;
      rf_rdata <= ~rf_rdata;
    end else if (rf_rd === 1'b1 || rf_wr === 1'b1) begin
      if (stall != 0) begin
        stall <= stall - 2'h1;
      end else begin
        // own draw variable: the stimulus still needs its r after the access
        rf_r = $random(seed);
        rf_ack <= 1'b1;
        rf_rdata <= rf_r[7:0];
        rf_sent <= rf_r[7:0];
        seen_addr <= rf_addr;
        seen_wd <= rf_wdata;
        seen_wr <= rf_wr;
        rf_count <= rf_count + 1;
        stall <= rf_r[9:8];
      end
    end else begin
      rf_rdata <= ~rf_rdata;
    end
  end

  // op_ready low cycles, sampled mid-cycle where the combinational value has settled
  always @(negedge clk) begin
    if (op_ready === 1'b0) begin
      blocked <= blocked + 1;
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  function automatic logic [12:0] target(input logic [4:0] l, input logic [10:0] o);
    return {l[4:3], o};
  endfunction

  // caller starts right after an edge; pc_out of the previous op is checked at the taking edge
  task automatic op(input pcsi_pkg::pcsi_op_type k, input logic [10:0] o);
    op_valid <= 1'b1;
    op_kind <= k;
    op_operand <= o;
    @(posedge clk);
    check(op_ready, 1'b1);
    check(pc_out, exp_pc);
    case (k)
      pcsi_pkg::PCSI_OP_CALL, pcsi_pkg::PCSI_OP_INT_VECTOR: begin
        stk[sp] = exp_pc + 13'h0001;
        sp = sp + 3'h1;
        exp_pc = (k == pcsi_pkg::PCSI_OP_CALL) ? target(lat, o) : `PCSI_INT_VECTOR;
      end
      pcsi_pkg::PCSI_OP_DIRECT_JUMP: exp_pc = target(lat, o);
      pcsi_pkg::PCSI_OP_RETURN, pcsi_pkg::PCSI_OP_EXIT_WITH_LITERAL, pcsi_pkg::PCSI_OP_EXIT_FROM_INTERRUPT: begin
        sp = sp - 3'h1;
        exp_pc = stk[sp];
      end
      pcsi_pkg::PCSI_OP_INCREMENT: exp_pc = exp_pc + 13'h0001;
      default: exp_pc = exp_pc;
    endcase
  endtask

  task automatic op_end;
    op_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(pc_out, exp_pc);
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, op_valid, rf_ack, seen_wr} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, op_operand, rf_rdata} = 0;
    op_kind = pcsi_pkg::PCSI_OP_NONE;
    {mismatches, compares, cycles, rf_count, blocked} = 0;
    seed = 32'hB50E;
    sp = 3'h0;
    stall = 2'h0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(pc_out, 13'h0000);
    for (i = 0; i < 2; i++) begin
      r = $random(seed);
      lat = r[4:0];
      lat8 = r[15:8];
      wr(`PCSI_ADR_PC_HIGH_LATCH, {27'h0, lat});
      wr(`PCSI_ADR_PC_LOW_BYTE, {24'h0, lat8});
      exp_pc = {lat, lat8};
      check(pc_out, exp_pc);
      rd(`PCSI_ADR_PC_LOW_BYTE);
      check(rdat, {24'h0, lat8});
      // stall first: first call sits on the take edge of the previous access
      @(posedge clk);
      for (int j = 0; j < 40; j++) begin
        r = $random(seed);
        op((j < 10) ? pcsi_pkg::PCSI_OP_CALL : (j < 20) ? pcsi_pkg::PCSI_OP_RETURN
           : pcsi_pkg::pcsi_op_type'(r[2:0]), r[18:8]);
      end
      op_end();
      rd(`PCSI_ADR_PC_HIGH_LATCH);
      check(rdat, {27'h0, lat});
    end
    // op held across a low-byte write: the write wins one cycle, increments resume after
    b0 = blocked;
    op_valid <= 1'b1;
    op_kind <= pcsi_pkg::PCSI_OP_INCREMENT;
    wr(`PCSI_ADR_PC_LOW_BYTE, 32'h0000_00FF);
    op_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(pc_out, 13'({lat, 8'hFF} + 13'h0001));
    check(blocked, b0 + 1);
    wb(1'b1, `PCSI_ADR_PC_HIGH_LATCH, 32'h0000_00FF, 4'hE);
    rd(`PCSI_ADR_PC_HIGH_LATCH);
    check(rdat, {27'h0, lat});
    rd(8'h14);
    check(rdat, 32'h0000_0000);
    wr(`PCSI_ADR_STATUS, 32'h0000_00FF);
    rd(`PCSI_ADR_STATUS);
    check(rdat, 32'h0000_0080);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : r[7:0];
      wr(`PCSI_ADR_STATUS, {24'h0, r[8], 7'h00});
      wr(`PCSI_ADR_POINTER_REGISTER, {24'h0, p});
      n0 = rf_count;
      rd(`PCSI_ADR_INDIRECT_DATA_PORT);
      // self-select: port answers zero and the file is never strobed
      check(rdat, (p[6:0] == 7'h00) ? 32'h0 : {24'h0, rf_sent});
      check(seen_addr, (p[6:0] == 7'h00) ? seen_addr : {r[8], p});
      wr(`PCSI_ADR_INDIRECT_DATA_PORT, {24'h0, r[23:16]});
      check(rf_count, (p[6:0] == 7'h00) ? n0 : n0 + 2);
      check({seen_wr, seen_wd}, (p[6:0] == 7'h00) ? {seen_wr, seen_wd} : {1'b1, r[23:16]});
    end
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(pc_out, 13'h0000);
    rd(`PCSI_ADR_PC_HIGH_LATCH);
    check(rdat, 32'h0000_0000);
    report_and_stop;
  end
endmodule

`default_nettype wire
